/* File: rtl/pew_writer.sv */
// Pedestal subtraction and event record writer into the look-back region
`timescale 1ns/1ps
`default_nettype none
module pew_writer (
    input wire logic clock_i,
    input wire logic resetn_i,
    // Pedestal load port from the host bridge
    input wire logic ped_wr_i,
    input wire logic [31:0] ped_addr_i,
    input wire logic [31:0] ped_data_i,
    // Event control
    input wire logic launch_i,
    input wire logic start_i,
    input wire logic dig_sel_i,
    input wire logic fs_en_i,
    input wire logic dig_en_i,
    input wire logic save_both_i,
    input wire logic [31:0] evt_time_i,
    // Data stream: fast-sampler words, raw samples, compressed words
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [31:0] in_data_i,
    input wire logic in_last_i,
    // Write master towards the SDRAM bridge
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output logic [31:0] wr_addr_o,
    output logic [31:0] wr_data_o,
    // Status
    output logic busy_o,
    output logic done_o
);
    // Whole sequencer state
    typedef struct packed {
        pew_pkg::pew_state_t st; // Sequencer state
        logic dig; // Digitizer B selected
        logic fs_en; // Fast-sampler section present
        logic dig_en; // Digitizer section present
        logic both; // Compressed record follows the raw one
        logic cmp_rec; // Current record is the compressed one
        logic [pew_pkg::SLOT_W-1:0] slot; // Next 2 kbyte slot
        logic [6:0] cnt; // Sample, word or header index
        logic [1:0] ch; // Digitizer channel
        logic half; // First sample of a pair held
        logic [pew_pkg::PED_W-1:0] held; // Higher-numbered sample of the pair
        logic [8:0] cmp_n; // Compressed words written, at most CMP_WORDS
        logic dead_run; // Dead-time counter running
        logic [5:0] dead_acc; // Nanosecond remainder
        logic [31:0] dead_cnt; // Running dead time
        logic [31:0] dead; // Dead time of current event
        logic [31:0] time_s; // Event time for the header
        logic done; // Record set complete
    } pew_st_t;

    pew_st_t r;
    pew_st_t next_r;
    logic [pew_pkg::PED_W-1:0] ped_mem [0:pew_pkg::PED_DEPTH-1]; // Pedestal patterns
    logic ped_hit; // Load address falls in the pattern window
    logic [pew_pkg::PED_IDX_W-1:0] ped_idx; // Load entry index
    logic [pew_pkg::PED_W-1:0] ped_val; // Pedestal for the current sample
    logic [pew_pkg::PED_W-1:0] sub; // Corrected current sample
    logic take; // Input word accepted
    logic push; // Write request into the buffer
    logic [pew_pkg::OFS_W-1:0] push_ofs; // Offset within the record
    logic [31:0] push_data; // Word to write
    logic buf_rdy; // Buffer has room
    logic [pew_pkg::REQ_W-1:0] req_out; // Buffered address and data
    logic [5:0] acc_sum; // Dead-time remainder plus one clock

    // Map a load byte address to an entry; A and B share one layout
    function automatic logic [pew_pkg::PED_IDX_W:0] ped_decode(input logic [31:0] a);
        logic [31:0] ofs;
        ofs = a - pew_pkg::PED_A_BASE;
        // Bit 11 picks digitizer B, bits 10-9 channel, 8-2 storage slot
        ped_decode = {(ofs < pew_pkg::PED_SPAN) && (ofs[1:0] == 2'h0), ofs[11:2]};
    endfunction

    // Raw minus signed pedestal with clamping to the sample range
    function automatic logic [pew_pkg::PED_W-1:0] clamp_sub(input logic [9:0] raw, input logic [9:0] ped);
        logic signed [11:0] diff;
        diff = $signed({2'b00, raw}) - $signed({{2{ped[9]}}, ped});
        if (diff <= 12'sd0) begin
            clamp_sub = '0;
        end else if (diff >= $signed({2'b00, pew_pkg::SAMPLE_MAX})) begin
            clamp_sub = pew_pkg::SAMPLE_MAX;
        end else begin
            clamp_sub = diff[9:0];
        end
    endfunction

    assign {ped_hit, ped_idx} = ped_decode(ped_addr_i);

    // Pattern storage; upper word bits are dropped, no reset on contents
    always_ff @(posedge clock_i) begin
        if (ped_wr_i && ped_hit) begin
            ped_mem[ped_idx] <= ped_data_i[pew_pkg::PED_W-1:0];
        end
    end

    // Samples arrive 127 first, so the arrival index is the storage slot
    assign ped_val = ped_mem[{r.dig, r.ch, r.cnt}];
    assign sub = clamp_sub(in_data_i[9:0], ped_val);
    assign take = in_valid_i && in_ready_o;
    assign acc_sum = r.dead_acc + pew_pkg::CLK_STEP;
    assign busy_o = (r.st != pew_pkg::PEW_IDLE);
    assign done_o = r.done;

    // Input is held off whenever the buffer is full, so only compressed words past the slot's room are lost
    always_comb begin
        case (r.st)
            pew_pkg::PEW_FS, pew_pkg::PEW_DIG, pew_pkg::PEW_CMP: in_ready_o = buf_rdy;
            default: in_ready_o = 1'b0;
        endcase
    end

    // Sequencer, dead-time counter and write request generation
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        push = 1'b0;
        push_ofs = '0;
        push_data = '0;
        // Dead time in 25 ns units from a 20 ns clock via a remainder
        if (launch_i) begin
            next_r.dead_run = 1'b1;
            next_r.dead_acc = '0;
            next_r.dead_cnt = '0;
        end else if (r.dead_run) begin
            if (acc_sum >= pew_pkg::DEAD_STEP) begin
                next_r.dead_acc = acc_sum - pew_pkg::DEAD_STEP;
                next_r.dead_cnt = r.dead_cnt + 32'h1;
            end else begin
                next_r.dead_acc = acc_sum;
            end
        end
        case (r.st)
            pew_pkg::PEW_IDLE: begin
                // Start marks data entering the buffer: dead time stops
                if (start_i) begin
                    next_r.dig = dig_sel_i;
                    next_r.fs_en = fs_en_i;
                    next_r.dig_en = dig_en_i;
                    next_r.both = save_both_i;
                    next_r.cmp_rec = 1'b0;
                    next_r.cnt = '0;
                    next_r.ch = '0;
                    next_r.half = 1'b0;
                    next_r.cmp_n = '0;
                    next_r.time_s = evt_time_i;
                    next_r.dead = r.dead_cnt;
                    next_r.dead_run = launch_i;
                    if (fs_en_i) begin
                        next_r.st = pew_pkg::PEW_FS;
                    end else if (dig_en_i) begin
                        next_r.st = pew_pkg::PEW_DIG;
                    end else begin
                        next_r.st = pew_pkg::PEW_HDR;
                    end
                end
            end
            pew_pkg::PEW_FS: begin
                if (take) begin
                    push = 1'b1;
                    push_ofs = pew_pkg::OFS_FS + {2'b00, r.cnt, 2'b00};
                    push_data = in_data_i;
                    next_r.cnt = r.cnt + 7'h1;
                    if (r.cnt == pew_pkg::LAST_SAMPLE) begin
                        next_r.st = r.dig_en ? pew_pkg::PEW_DIG : pew_pkg::PEW_HDR;
                    end
                end
            end
            pew_pkg::PEW_DIG: begin
                if (take) begin
                    if (!r.half) begin
                        // Higher-numbered sample waits for its partner
                        next_r.held = sub;
                        next_r.half = 1'b1;
                    end else begin
                        push = 1'b1;
                        push_ofs = pew_pkg::OFS_DIG + {1'b0, r.ch, 8'h00} + {3'b000, r.cnt[6:1], 2'b00};
                        push_data = {6'h00, sub, 6'h00, r.held};
                        next_r.half = 1'b0;
                    end
                    next_r.cnt = r.cnt + 7'h1;
                    if (r.cnt == pew_pkg::LAST_SAMPLE) begin
                        next_r.ch = r.ch + 2'h1;
                        if (r.ch == pew_pkg::LAST_CH) begin
                            next_r.st = pew_pkg::PEW_HDR;
                        end
                    end
                end
            end
            pew_pkg::PEW_HDR: begin
                // Header last, so the dead time and sizes are already known
                if (buf_rdy) begin
                    push = 1'b1;
                    push_ofs = pew_pkg::OFS_HDR + {7'h00, r.cnt[1:0], 2'b00};
                    case (r.cnt[1:0])
                        2'h0: push_data = {28'h0000000, r.cmp_rec, r.dig_en & ~r.cmp_rec,
                                           r.fs_en & ~r.cmp_rec, r.dig};
                        2'h1: push_data = r.time_s;
                        2'h2: push_data = r.dead;
                        default: push_data = {23'h000000, r.cmp_n};
                    endcase
                    next_r.cnt = r.cnt + 7'h1;
                    if (r.cnt[1:0] == pew_pkg::LAST_HDR) begin
                        next_r.cnt = '0;
                        next_r.slot = r.slot + 13'h0001;
                        if (r.both && !r.cmp_rec) begin
                            next_r.cmp_rec = 1'b1;
                            next_r.st = pew_pkg::PEW_CMP;
                        end else begin
                            next_r.done = 1'b1;
                            next_r.st = pew_pkg::PEW_IDLE;
                        end
                    end
                end
            end
            pew_pkg::PEW_CMP: begin
                // Words past the slot's room are accepted and dropped
                if (take) begin
                    if (r.cmp_n < pew_pkg::CMP_WORDS) begin
                        push = 1'b1;
                        push_ofs = pew_pkg::OFS_FS + {r.cmp_n, 2'b00};
                        push_data = in_data_i;
                        next_r.cmp_n = r.cmp_n + 9'h001;
                    end
                    if (in_last_i) begin
                        next_r.st = pew_pkg::PEW_HDR;
                    end
                end
            end
            default: begin
                next_r.st = pew_pkg::PEW_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Address always lands inside the look-back region, slot aligned
    pew_buf2 #(
        .W(pew_pkg::REQ_W)
    ) u_buf (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .in_valid_i(push),
        .in_ready_o(buf_rdy),
        .in_data_i({pew_pkg::LB_TOP, r.slot, push_ofs, push_data}),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i),
        .out_data_o(req_out)
    );

    assign wr_addr_o = req_out[63:32];
    assign wr_data_o = req_out[31:0];
endmodule
`default_nettype wire

/* File: rtl/pew_pkg.sv */
// Constants shared by the pedestal event writer and its output buffer
// Overview of operation
// - Pedestal is low ten bits, signed
// - Per-channel patterns, lowest address holds sample 127
// - Digitizer A patterns start at 90001000
// - Raw minus pedestal, clamped to 0..1023
// - Records only in look-back region, 32-bit writes
// - Every record starts on 2 kbyte boundary
// - Save-both writes raw and compressed records
// - Raw record: header, fast sampler, digitizer; header +0
// - Fast-sampler data starts at offset +10
// - Digitizer channels at +210, +310, +410, +510
// - Two samples per word, higher sample low
// - Dead time counts 25 ns units
package pew_pkg;
    // Pedestal memory window as seen on the load port
    localparam logic [31:0] PED_A_BASE = 32'h9000_1000;
    localparam logic [31:0] PED_B_OFS = 32'h0000_0800;
    localparam logic [31:0] PED_SPAN = 32'h0000_1000;
    localparam int PED_W = 10;
    localparam int PED_IDX_W = 10;
    localparam int PED_DEPTH = 1024;
    // Sample geometry
    localparam logic [6:0] LAST_SAMPLE = 7'h7F;
    localparam logic [1:0] LAST_CH = 2'h3;
    localparam logic [1:0] LAST_HDR = 2'h3;
    localparam logic [9:0] SAMPLE_MAX = 10'h3FF;
    // Look-back region, one record per 2 kbyte slot
    localparam logic [7:0] LB_TOP = 8'h01;
    localparam int SLOT_W = 13;
    localparam int OFS_W = 11;
    localparam logic [10:0] OFS_HDR = 11'h000;
    localparam logic [10:0] OFS_FS = 11'h010;
    localparam logic [10:0] OFS_DIG = 11'h210;
    localparam logic [10:0] CH_STRIDE = 11'h100;
    localparam logic [8:0] CMP_WORDS = 9'h1FC;
    // Dead time unit against the fabric clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int DEAD_UNIT_NS = 25;
    localparam logic [5:0] CLK_STEP = 6'(CLK_PERIOD_NS);
    localparam logic [5:0] DEAD_STEP = 6'(DEAD_UNIT_NS);
    // Write request width: address plus data
    localparam int REQ_W = 64;
    // Sequencer states
    typedef enum logic [2:0] {
        PEW_IDLE = 3'b000,
        PEW_FS = 3'b001,
        PEW_DIG = 3'b010,
        PEW_HDR = 3'b011,
        PEW_CMP = 3'b100
    } pew_state_t;
endpackage

/* File: rtl/pew_buf2.sv */
// Two-entry buffer between the record sequencer and the SDRAM bridge
`timescale 1ns/1ps
`default_nettype none
module pew_buf2 #(
    parameter int W = 64
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    // Whole buffer state
    typedef struct packed {
        logic [W-1:0] d0; // Head entry, drives the output
        logic [W-1:0] d1; // Second entry
        logic [1:0] cnt; // Entries held
    } pew_buf_t;

    pew_buf_t r;
    pew_buf_t next_r;
    logic push;
    logic pop;

    // Full and empty straight from the count, so back-pressure is honest
    assign in_ready_o = (r.cnt != 2'h2);
    assign out_valid_o = (r.cnt != 2'h0);
    assign out_data_o = r.d0;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Next-state: shift on pop, fill the first free slot on push
    always_comb begin
        next_r = r;
        case ({push, pop})
            2'b10: begin
                if (r.cnt == 2'h0) begin
                    next_r.d0 = in_data_i;
                end else begin
                    next_r.d1 = in_data_i;
                end
                next_r.cnt = r.cnt + 2'h1;
            end
            2'b01: begin
                next_r.d0 = r.d1;
                next_r.cnt = r.cnt - 2'h1;
            end
            2'b11: begin
                // Count stays; only one entry is moving through
                if (r.cnt == 2'h1) begin
                    next_r.d0 = in_data_i;
                end else begin
                    next_r.d0 = r.d1;
                    next_r.d1 = in_data_i;
                end
            end
            default: begin
                next_r = r;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule
`default_nettype wire

/* File: verification/pew_writer_properties.sv */
// Checker for the pedestal event writer ports
`timescale 1ns/1ps
`default_nettype none
module pew_writer_properties (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic in_ready_o,
    input wire logic wr_valid_o,
    input wire logic wr_ready_i,
    input wire logic [31:0] wr_addr_o,
    input wire logic [31:0] wr_data_o,
    input wire logic busy_o,
    input wire logic done_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Start accepted only from idle
    sequence s_start;
        !busy_o && start_i;
    endsequence
    // Header phase alone lasts several cycles
    sequence s_run;
        busy_o [*2];
    endsequence
    property p_region; wr_valid_o |-> wr_addr_o[31:24] == 8'h01; endproperty
    a_region: assert property (p_region) else $error("write outside region");
    property p_word; wr_valid_o |-> wr_addr_o[1:0] == 2'h0; endproperty
    a_word: assert property (p_word) else $error("unaligned write");
    // A stalled request must not move under the bridge
    property p_hold;
        wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed while stalled");
    property p_idle; !busy_o |-> !in_ready_o; endproperty
    a_idle: assert property (p_idle) else $error("ready while idle");
    property p_pulse; done_o |=> !done_o; endproperty
    a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
    property p_done_idle; done_o |-> !busy_o; endproperty
    a_done_idle: assert property (p_done_idle) else $error("done while busy");
    property p_start; s_start |=> s_run; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_end; $fell(busy_o) |-> done_o; endproperty
    a_end: assert property (p_end) else $error("set ended without done");
endmodule
bind pew_writer pew_writer_properties chk (.clock_i(clock_i), .resetn_i(resetn_i), .start_i(start_i),
    .in_ready_o(in_ready_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .busy_o(busy_o), .done_o(done_o));
`default_nettype wire

/* File: verification/pew_bridge_model.sv */
// Behavioural SDRAM bridge that records every accepted write
`timescale 1ns/1ps
`default_nettype none
module pew_bridge_model (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic slow_i,
    input wire logic wr_valid_i,
    input wire logic [31:0] wr_addr_i,
    input wire logic [31:0] wr_data_i,
    output logic wr_ready_o
);
    logic [31:0] mem [logic [31:0]]; // Written words by address
    int n_wr = 0;
    int n_bad = 0;
    logic [1:0] cnt; // Slow mode accepts one cycle in four
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) cnt <= 2'h0;
        else cnt <= cnt + 2'h1;
    end
    assign wr_ready_o = resetn_i && (!slow_i || cnt == 2'h0);
    // Store accepted words; anything outside the region is counted as bad
    always @(posedge clock_i) begin
        if (resetn_i && wr_valid_i && wr_ready_o) begin
            mem[wr_addr_i] = wr_data_i;
            n_wr++;
            if (wr_addr_i[31:24] != 8'h01 || wr_addr_i[1:0] != 2'h0) n_bad++;
        end
    end
endmodule
`default_nettype wire

/* File: verification/test_pedestal_event_writer.sv */
// Self-checking bench for the pedestal event writer
`timescale 1ns/1ps
`default_nettype none
module test_pedestal_event_writer;
    logic clock_i, resetn_i, ped_wr_i, launch_i, start_i, dig_sel_i, fs_en_i, dig_en_i, save_both_i;
    logic in_valid_i, in_ready_o, in_last_i, wr_valid_o, wr_ready_i, busy_o, done_o, slow;
    logic [31:0] ped_addr_i, ped_data_i, evt_time_i, in_data_i, wr_addr_o, wr_data_o;
    logic [9:0] ped [1024]; // Bench copy of the pedestal memory
    int n_errors = 0;
    int checks_done = 0;
    int n_done = 0; // Done pulses seen, sampled mid-cycle where settled
    pew_writer dut (.clock_i(clock_i), .resetn_i(resetn_i), .ped_wr_i(ped_wr_i), .ped_addr_i(ped_addr_i),
        .ped_data_i(ped_data_i), .launch_i(launch_i), .start_i(start_i), .dig_sel_i(dig_sel_i),
        .fs_en_i(fs_en_i), .dig_en_i(dig_en_i), .save_both_i(save_both_i), .evt_time_i(evt_time_i),
        .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .in_data_i(in_data_i), .in_last_i(in_last_i),
        .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
        .busy_o(busy_o), .done_o(done_o));
    pew_bridge_model bridge (.clock_i(clock_i), .resetn_i(resetn_i), .slow_i(slow), .wr_valid_i(wr_valid_o),
        .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o), .wr_ready_o(wr_ready_i));
    // Count done pulses so each event set can be judged on exactly one
    always @(negedge clock_i) begin
        if (done_o === 1'b1) n_done++;
    end
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Fetch a recorded word; a missing word reads as a marker
    function automatic logic [31:0] rd(input logic [31:0] a);
        return bridge.mem.exists(a) ? bridge.mem[a] : 32'hDEAD_BEEF;
    endfunction
    function automatic int raw(input int ch, input int s);
        return (ch * 200 + s * 3 + 100) % 1024;
    endfunction
    // Expected corrected sample with clamping
    function automatic logic [9:0] corr(input int r, input logic [9:0] p);
        int d;
        d = r - int'($signed(p));
        return (d <= 0) ? 10'h000 : (d >= 1023) ? 10'h3FF : 10'(d);
    endfunction
    task automatic ped_load(input int idx, input logic [9:0] v);
        ped_wr_i <= 1'b1; // Held high across back-to-back loads
        ped_addr_i <= 32'h9000_1000 + 32'(idx * 4);
        ped_data_i <= {22'h0, v};
        ped[idx] = v;
        @(posedge clock_i);
    endtask
    // Offer one word and hold it until the writer takes it
    task automatic send(input logic [31:0] d, input logic l);
        logic ok;
        in_valid_i <= 1'b1;
        in_data_i <= d;
        in_last_i <= l;
        do begin
            @(negedge clock_i);
            ok = in_ready_o;
            @(posedge clock_i);
        end while (!ok);
    endtask
    // One event set: stream, wait for all writes, check the done pulse, then judge the records
    task automatic ev(input logic sel, fs, dig, both, input int slot, ncmp, nwr);
        logic [31:0] b;
        int n, s, p0, ex, nk, d0;
        b = 32'h0100_0000 + 32'(slot) * 32'h800;
        nk = (ncmp > 508) ? 508 : ncmp; // Compressed words that fit in one slot
        d0 = n_done;
        launch_i <= 1'b1;
        @(posedge clock_i);
        launch_i <= 1'b0;
        repeat (49) @(posedge clock_i);
        {dig_sel_i, fs_en_i, dig_en_i, save_both_i} <= {sel, fs, dig, both};
        evt_time_i <= 32'h1234_0000 + 32'(slot);
        start_i <= 1'b1;
        @(posedge clock_i);
        start_i <= 1'b0;
        ex = bridge.n_wr + nwr;
        if (fs) for (int i = 0; i < 128; i++) send(32'h0101_0101 * 32'(i), 1'b0);
        if (dig) for (int c = 0; c < 4; c++) for (s = 127; s >= 0; s--) begin
            start_i <= (both && c == 1 && s == 64); // A start while busy must be ignored
            send(32'(raw(c, s)), 1'b0);
        end
        start_i <= 1'b0;
        for (int i = 0; i < ncmp; i++) send(32'hC0DE_0000 + 32'(i), i == ncmp - 1);
        in_valid_i <= 1'b0;
        n = 0;
        while (bridge.n_wr < ex && n < 20000) begin
            @(posedge clock_i);
            n++;
        end
        @(negedge clock_i);
        chk(32'(bridge.n_wr), 32'(ex));
        chk(32'(n_done - d0), 32'h1);
        chk(32'(busy_o), 32'h0);
        chk(rd(b), {28'h0, 1'b0, dig, fs, sel});
        chk(rd(b + 32'h4), 32'h1234_0000 + 32'(slot));
        chk(rd(b + 32'hC), 32'h0);
        chk(32'(rd(b + 32'h8) >= 39 && rd(b + 32'h8) <= 41), 32'h1);
        if (fs) for (int i = 0; i < 128; i++) chk(rd(b + 32'h10 + 32'(i * 4)), 32'h0101_0101 * 32'(i));
        if (dig) for (int c = 0; c < 4; c++) for (int k = 0; k < 64; k++) begin
            s = 127 - 2 * k;
            p0 = int'(sel) * 512 + c * 128 + 2 * k;
            chk(rd(b + 32'h210 + 32'(c * 256 + k * 4)), {6'h0, corr(raw(c, s - 1), ped[p0 + 1]), 6'h0,
                corr(raw(c, s), ped[p0])});
        end
        if (both) begin
            chk(rd(b + 32'h800 + 32'hC), 32'(nk));
            chk(rd(b + 32'h800) & 32'h8, 32'h8);
            for (int i = 0; i < nk; i++) chk(rd(b + 32'h810 + 32'(i * 4)), 32'hC0DE_0000 + 32'(i));
        end
        @(posedge clock_i);
    endtask
    initial begin
        {resetn_i, ped_wr_i, launch_i, start_i, dig_sel_i, fs_en_i, dig_en_i, save_both_i} = 8'h00;
        {in_valid_i, in_last_i, slow} = 3'h0;
        {ped_addr_i, ped_data_i, evt_time_i, in_data_i} = 128'h0;
        repeat (12) @(posedge clock_i);
        #5 resetn_i = 1'b1;
        chk(32'({in_ready_o, wr_valid_o, busy_o, done_o}), 32'h0);
        chk(wr_addr_o | wr_data_o, 32'h0);
        @(posedge clock_i);
        for (int i = 0; i < 1024; i++) ped_load(i, 10'h000);
        ped_load(0, 10'h3FF);
        ped_load(1, 10'h1FF);
        ped_load(2, 10'h200);
        ped_load(128, 10'h0C8);
        ped_load(129, 10'h200);
        ped_load(512, 10'h064);
        ped_wr_i <= 1'b0;
        @(posedge clock_i);
        ev(1'b0, 1'b0, 1'b1, 1'b0, 0, 0, 260);
        slow = 1'b1;
        ev(1'b1, 1'b1, 1'b1, 1'b1, 1, 3, 395);
        ev(1'b0, 1'b1, 1'b0, 1'b1, 3, 510, 644);
        ev(1'b1, 1'b0, 1'b0, 1'b0, 5, 0, 4);
        chk(32'(bridge.n_bad), 32'h0);
        complete_run();
    end
    initial begin
        #(20 * 60000);
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
